// ---- rtl/sbp_pkg.sv ----
// Package of constants and types for the status and block-protect block
package sbp_pkg;
  // Status byte bit positions
  localparam int unsigned STAT_SRWD_BIT  = 7;  // Status-write disable
  localparam int unsigned STAT_BP3_BIT   = 6;  // Top block-protect bit
  localparam int unsigned STAT_TB_BIT    = 5;  // Top/bottom select
  localparam int unsigned STAT_BP_LO_MSB = 4;  // Low protect bits 4:2
  localparam int unsigned STAT_BP_LO_LSB = 2;
  localparam int unsigned STAT_WEL_BIT   = 1;  // Write-enable latch
  localparam int unsigned STAT_BUSY_BIT  = 0;  // Write in progress

  // Reset values of the nonvolatile bits
  localparam logic       SRWD_RST = 1'b1;    // Status writes disabled while pin low
  localparam logic       TB_RST   = 1'b1;    // Bottom anchored
  localparam logic [3:0] BP_RST   = 4'h0;    // Nothing protected

  // Array geometry: 26-bit byte address, sector = bits 25:16
  localparam int unsigned ADDR_W       = 26;
  localparam int unsigned SECT_MSB     = 25;
  localparam int unsigned SECT_LSB     = 16;
  localparam int unsigned SECT_W       = 10;
  localparam logic [10:0] SECT_COUNT   = 11'h400;  // 1024 sectors
  localparam logic [3:0]  BP_ALL_CODE  = 4'hb;     // Codes >= this: all
  localparam logic [3:0]  BP_NONE_CODE = 4'h0;

  // Status-write cycle time and its length in clock cycles
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SRW_TIME_NS   = 1000;
  localparam int unsigned SRW_CYCLES_I  =
    (SRW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SRW_CYCLES    = SRW_CYCLES_I[7:0];

  // Commands from the serial command decoder
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_READ_STATUS,
    CMD_READ_FLAG,
    CMD_WRITE_STATUS,
    CMD_WRITE_ENABLE,
    CMD_WRITE_DISABLE,
    CMD_PROGRAM,
    CMD_SECTOR_ERASE,
    CMD_SUBSECTOR_ERASE,
    CMD_WHOLE_ARRAY_ERASE
  } sbp_cmd_code_t;

  // One decoded command
  typedef struct packed {
    sbp_cmd_code_t     code;  // What to do
    logic [ADDR_W-1:0] addr;  // Target byte address
    logic [7:0]        data;  // Status write value
  } sbp_cmd_t;

  // One array operation handed to the array engine
  typedef struct packed {
    sbp_cmd_code_t     code;  // Program or erase kind
    logic [ADDR_W-1:0] addr;  // Target byte address
  } sbp_op_t;
endpackage

// ---- rtl/sbp_status_protect.sv ----
// Status register, block-protect decode and command gating
//
// Notes on behaviour
// - Status readable and writable by commands
// - Locked when disable bit set, pin low
// - Bit 7 disables status writes while pin low, default one
// - Bit 5 picks top or bottom anchor
// - Protect bits refuse program and erase
// - Code n protects 2^(n-1) sectors, 11+ all
// - Write-enable latch needed, cleared at reset
// - Busy bit set during write cycles
// - Whole erase only with protect bits zero
// - Busy bit inverts flag ready bit
// - Array of 1024 sectors, 26-bit addresses
// - Flag ready low while cycle runs
// - Pin low with bit 7 enforces protection
`timescale 1ns/1ps
module sbp_status_protect (
  input  wire logic             mclk_in,        // System clock
  input  wire logic             rstn_in,        // Async reset, low
  input  wire logic             wp_n_in,        // Write-protect pin
  input  wire logic             cmd_valid_in,   // Command present
  input  wire sbp_pkg::sbp_cmd_t cmd_in,        // Decoded command
  input  wire logic             op_done_in,     // Array op finished
  output logic [7:0]            stat_out,       // Live status byte
  output logic                  flag_ready_out, // Flag ready bit
  output logic                  rd_valid_out,   // Read answer strobe
  output logic [7:0]            rd_data_out,    // Read answer byte
  output logic                  op_start_out,   // Array op launched
  output sbp_pkg::sbp_op_t      op_out,         // Launched op
  output logic                  prot_err_out    // Op refused, protected
);
  // Controller states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SR_WRITE,
    ST_ARRAY_OP
  } sbp_state_t;

  // Pin synchroniser
  logic wp_meta_ff;                // First stage, read by second only
  logic wp_sync_ff;                // Synchronised pin level

  // Status state
  logic       srwd_ff, nxt_srwd;   // Status-write disable
  logic       tb_ff, nxt_tb;       // Top/bottom select
  logic [3:0] bp_ff, nxt_bp;       // Block-protect code
  logic       wel_ff, nxt_wel;     // Write-enable latch
  logic       busy_ff, nxt_busy;   // Write in progress
  logic       ready_ff, nxt_ready; // Flag ready copy
  sbp_state_t state_ff, nxt_state; // Controller state
  logic [7:0] tmr_ff, nxt_tmr;     // Status-write timer

  // Answer outputs
  logic             rdv_ff, nxt_rdv;
  logic [7:0]       rdd_ff, nxt_rdd;
  logic             go_ff, nxt_go;
  sbp_pkg::sbp_op_t op_ff, nxt_op;
  logic             perr_ff, nxt_perr;

  // Decode helpers
  logic                       locked;     // Status writes blocked
  logic [sbp_pkg::SECT_W-1:0] sect;       // Target sector
  logic [10:0]                prot_cnt;   // Sectors protected
  logic                       in_prot;    // Target is protected
  logic [7:0]                 stat_now;   // Status byte now

  // Two-flop synchroniser on the pin
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_meta_ff <= 1'b1;
      wp_sync_ff <= 1'b1;
    end else begin
      wp_meta_ff <= wp_n_in;
      wp_sync_ff <= wp_meta_ff;
    end
  end

  // Protected range decode
  always_comb begin
    locked = srwd_ff && !wp_sync_ff;
    sect   = cmd_in.addr[sbp_pkg::SECT_MSB:sbp_pkg::SECT_LSB];
    // Sector count from the code
    if (bp_ff == sbp_pkg::BP_NONE_CODE) begin
      prot_cnt = 11'h000;
    end else if (bp_ff >= sbp_pkg::BP_ALL_CODE) begin
      prot_cnt = sbp_pkg::SECT_COUNT;
    end else begin
      prot_cnt = 11'h001 << (bp_ff - 4'h1);
    end
    // Anchor at bottom or top
    if (tb_ff) begin
      in_prot = {1'b0, sect} < prot_cnt;
    end else begin
      in_prot = {1'b0, ~sect} < prot_cnt;
    end
    stat_now = {srwd_ff, bp_ff[3], tb_ff, bp_ff[2:0], wel_ff, busy_ff};
  end

  // Command handling and busy tracking
  always_comb begin
    nxt_srwd  = srwd_ff;
    nxt_tb    = tb_ff;
    nxt_bp    = bp_ff;
    nxt_wel   = wel_ff;
    nxt_state = state_ff;
    nxt_tmr   = tmr_ff;
    nxt_rdv   = 1'b0;
    nxt_rdd   = rdd_ff;
    nxt_go    = 1'b0;
    nxt_op    = op_ff;
    nxt_perr  = 1'b0;
    // Reads are answered in any state
    if (cmd_valid_in && cmd_in.code == sbp_pkg::CMD_READ_STATUS) begin
      nxt_rdv = 1'b1;
      nxt_rdd = stat_now;
    end else if (cmd_valid_in && cmd_in.code == sbp_pkg::CMD_READ_FLAG) begin
      nxt_rdv = 1'b1;
      nxt_rdd = {!busy_ff, 7'h00};
    end
    unique case (state_ff)
      ST_IDLE: begin
        if (cmd_valid_in) begin
          unique case (cmd_in.code)
            sbp_pkg::CMD_WRITE_ENABLE: begin
              nxt_wel = 1'b1;
            end
            sbp_pkg::CMD_WRITE_DISABLE: begin
              nxt_wel = 1'b0;
            end
            // Status write needs latch and no lock
            sbp_pkg::CMD_WRITE_STATUS: begin
              if (wel_ff && !locked) begin
                nxt_srwd  = cmd_in.data[sbp_pkg::STAT_SRWD_BIT];
                nxt_tb    = cmd_in.data[sbp_pkg::STAT_TB_BIT];
                nxt_bp    = {cmd_in.data[sbp_pkg::STAT_BP3_BIT],
                             cmd_in.data[sbp_pkg::STAT_BP_LO_MSB:
                                         sbp_pkg::STAT_BP_LO_LSB]};
                nxt_state = ST_SR_WRITE;
                nxt_tmr   = sbp_pkg::SRW_CYCLES;
              end
            end
            // Whole erase only with no protect bits
            sbp_pkg::CMD_WHOLE_ARRAY_ERASE: begin
              if (wel_ff && bp_ff == sbp_pkg::BP_NONE_CODE) begin
                nxt_go    = 1'b1;
                nxt_op    = '{code: cmd_in.code, addr: cmd_in.addr};
                nxt_state = ST_ARRAY_OP;
              end else if (wel_ff) begin
                nxt_perr = 1'b1;
              end
            end
            // Program and erase checked against range
            sbp_pkg::CMD_PROGRAM,
            sbp_pkg::CMD_SECTOR_ERASE,
            sbp_pkg::CMD_SUBSECTOR_ERASE: begin
              if (wel_ff && !in_prot) begin
                nxt_go    = 1'b1;
                nxt_op    = '{code: cmd_in.code, addr: cmd_in.addr};
                nxt_state = ST_ARRAY_OP;
              end else if (wel_ff) begin
                nxt_perr = 1'b1;
              end
            end
            default: begin
              // Reads and no-ops leave state alone
            end
          endcase
        end
      end
      // Timed status write cycle
      ST_SR_WRITE: begin
        nxt_tmr = tmr_ff - 8'h01;
        if (tmr_ff == 8'h01) begin
          nxt_state = ST_IDLE;
          nxt_wel   = 1'b0;
        end
      end
      // Wait for the array engine
      ST_ARRAY_OP: begin
        if (op_done_in) begin
          nxt_state = ST_IDLE;
          nxt_wel   = 1'b0;
        end
      end
    endcase
    nxt_busy  = nxt_state != ST_IDLE;
    nxt_ready = nxt_state == ST_IDLE;
  end

  // Register all state
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      srwd_ff  <= sbp_pkg::SRWD_RST;
      tb_ff    <= sbp_pkg::TB_RST;
      bp_ff    <= sbp_pkg::BP_RST;
      wel_ff   <= 1'b0;
      busy_ff  <= 1'b0;
      ready_ff <= 1'b1;
      state_ff <= ST_IDLE;
      tmr_ff   <= 8'h00;
      rdv_ff   <= 1'b0;
      rdd_ff   <= 8'h00;
      go_ff    <= 1'b0;
      op_ff    <= '0;
      perr_ff  <= 1'b0;
    end else begin
      srwd_ff  <= nxt_srwd;
      tb_ff    <= nxt_tb;
      bp_ff    <= nxt_bp;
      wel_ff   <= nxt_wel;
      busy_ff  <= nxt_busy;
      ready_ff <= nxt_ready;
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
      rdv_ff   <= nxt_rdv;
      rdd_ff   <= nxt_rdd;
      go_ff    <= nxt_go;
      op_ff    <= nxt_op;
      perr_ff  <= nxt_perr;
    end
  end

  // Outputs are flop copies
  assign stat_out       = {srwd_ff, bp_ff[3], tb_ff, bp_ff[2:0],
                           wel_ff, busy_ff};
  assign flag_ready_out = ready_ff;
  assign rd_valid_out   = rdv_ff;
  assign rd_data_out    = rdd_ff;
  assign op_start_out   = go_ff;
  assign op_out         = op_ff;
  assign prot_err_out   = perr_ff;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  // Command seen while idle
  sequence s_idle_cmd(sbp_pkg::sbp_cmd_code_t c);
    cmd_valid_in && cmd_in.code == c && state_ff == ST_IDLE;
  endsequence

  chk_busy_inverse: assert property (
    stat_out[0] == !flag_ready_out)
    else $error("Busy bit does not invert flag ready");
  chk_lock_holds: assert property (
    s_idle_cmd(sbp_pkg::CMD_WRITE_STATUS) ##0 locked
      |=> $stable(stat_out[7:2]) && !busy_ff)
    else $error("Locked status write was executed");
  chk_whole_guard: assert property (
    s_idle_cmd(sbp_pkg::CMD_WHOLE_ARRAY_ERASE) ##0 (bp_ff != 4'h0)
      |=> !op_start_out)
    else $error("Whole erase ran with protect bits set");
  chk_prot_abort: assert property (
    s_idle_cmd(sbp_pkg::CMD_PROGRAM) ##0 (wel_ff && in_prot)
      |=> prot_err_out && !op_start_out)
    else $error("Protected program not refused");
  chk_wel_needed: assert property (
    op_start_out |-> $past(wel_ff))
    else $error("Op launched without write enable");
  // Eight cycles of busy, a piece of the status write cycle
  sequence s_busy8;
    stat_out[0] [*8];
  endsequence

  // Busy for all twenty cycles, then idle with the latch cleared
  chk_sr_busy: assert property (
    s_idle_cmd(sbp_pkg::CMD_WRITE_STATUS) ##0 (wel_ff && !locked)
      |=> s_busy8 ##1 s_busy8 ##1 stat_out[0] [*4]
          ##1 (!stat_out[0] && !stat_out[1]))
    else $error("Status write busy time wrong");
  chk_read_data: assert property (
    cmd_valid_in && cmd_in.code == sbp_pkg::CMD_READ_STATUS
      |=> rd_valid_out && rd_data_out == $past(stat_out))
    else $error("Status read returned wrong byte");
  chk_all_protect: assert property (
    s_idle_cmd(sbp_pkg::CMD_SECTOR_ERASE) ##0 (wel_ff && bp_ff >= 4'hb)
      |=> prot_err_out)
    else $error("Code above ten did not protect all");
  chk_bottom_edge: assert property (
    s_idle_cmd(sbp_pkg::CMD_SUBSECTOR_ERASE) ##0 (wel_ff && tb_ff &&
      bp_ff == 4'h1 && sect == 10'h001) |=> op_start_out)
    else $error("Sector one wrongly protected at bottom");
endmodule

// ---- verif/sbp_engine_model.sv ----
// Array engine model that finishes launched program and erase work
`timescale 1ns/1ps
module sbp_engine_model (
  input  wire logic       mclk_in,     // Clock
  input  wire logic       op_start_in, // Launch strobe
  input  wire logic [3:0] lag_in,      // Extra cycles before done
  output logic            op_done_out  // Finish pulse
);
  // Wait for a launch, let the lag pass, then give a one-cycle done pulse
  initial begin
    op_done_out = 1'b0;
    forever begin
      @(posedge mclk_in);
      if (op_start_in) begin
        repeat (lag_in) @(negedge mclk_in);
        @(negedge mclk_in);
        op_done_out = 1'b1;
        @(negedge mclk_in);
        op_done_out = 1'b0;
      end
    end
  end
endmodule

// ---- verif/sbp_status_protect_bench.sv ----
// Self-checking bench for the status and block-protect block
`timescale 1ns/1ps
module sbp_status_protect_bench;
  logic              mclk_in = 1'b0;      // Clock
  logic              rstn_in = 1'b0;      // Reset, low
  logic              wp_n_in = 1'b1;      // Protect pin, high idle
  logic              cmd_valid_in = 1'b0; // Command strobe
  sbp_pkg::sbp_cmd_t cmd_in = '0;         // Command fields
  logic              op_done_in;          // From engine model
  logic [7:0]        stat_out;            // Status byte
  logic [7:0]        rd_data_out;         // Read answer
  logic              flag_ready_out;      // Flag ready
  logic              rd_valid_out;        // Read strobe
  logic              op_start_out;        // Launch strobe
  logic              prot_err_out;        // Refusal strobe
  sbp_pkg::sbp_op_t  op_out;              // Launched op
  logic [3:0]        lag = 4'h0;          // Engine delay
  int n_fail = 0;
  int samples_checked = 0;
  int m_srwd = 1, m_tb = 1, m_bp = 0, m_wel = 0; // Reference state

  always #25 mclk_in = ~mclk_in;

  sbp_status_protect u_sbp_status_protect (
    .mclk_in        (mclk_in),
    .rstn_in        (rstn_in),
    .wp_n_in        (wp_n_in),
    .cmd_valid_in   (cmd_valid_in),
    .cmd_in         (cmd_in),
    .op_done_in     (op_done_in),
    .stat_out       (stat_out),
    .flag_ready_out (flag_ready_out),
    .rd_valid_out   (rd_valid_out),
    .rd_data_out    (rd_data_out),
    .op_start_out   (op_start_out),
    .op_out         (op_out),
    .prot_err_out   (prot_err_out)
  );
  sbp_engine_model u_sbp_engine_model (
    .mclk_in     (mclk_in),
    .op_start_in (op_start_out),
    .lag_in      (lag),
    .op_done_out (op_done_in)
  );

  // Verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare one value
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Expected status byte
  function automatic logic [7:0] mstat();
    return {m_srwd[0], m_bp[3], m_tb[0], m_bp[2:0], m_wel[0], 1'b0};
  endfunction

  // Sectors covered by the current protect code
  function automatic int nprot();
    return m_bp == 0 ? 0 : m_bp >= 11 ? 1024 : 1 << (m_bp - 1);
  endfunction

  function automatic bit is_prot(logic [25:0] a);
    int s;
    s = a[25:16];
    return m_tb ? s < nprot() : s >= 1024 - nprot();
  endfunction

  // One command for one cycle, driven on the falling edge
  task automatic cmd(sbp_pkg::sbp_cmd_code_t c, logic [25:0] a,
                     logic [7:0] d);
    @(negedge mclk_in);
    cmd_in = '{code:c, addr:a, data:d};
    cmd_valid_in = 1'b1;
    @(negedge mclk_in);
    cmd_valid_in = 1'b0;
  endtask

  // Bounded wait for ready; flag must read busy while waiting
  task automatic wait_idle(output int n);
    n = 0;
    while (stat_out[0] !== 1'b0) begin
      check("flag", flag_ready_out, 0);
      @(negedge mclk_in);
      n++;
      if (n > 300) begin
        n_fail++;
        print_verdict();
      end
    end
    check("flag", flag_ready_out, 1);
  endtask

  // Status read answered one cycle later
  task automatic rd_check();
    cmd(sbp_pkg::CMD_READ_STATUS, 26'h0, 8'h00);
    check("rd_valid", rd_valid_out, 1);
    check("rd_data", rd_data_out, mstat());
  endtask

  // Flag read answered one cycle later, ready bit on top
  task automatic flag_check(bit busy);
    cmd(sbp_pkg::CMD_READ_FLAG, 26'h0, 8'h00);
    check("fl_valid", rd_valid_out, 1);
    check("fl_data", rd_data_out, busy ? 8'h00 : 8'h80);
  endtask

  // Status write, with or without a write enable first
  task automatic wr_stat(logic [7:0] d, bit wren);
    int n;
    bit acc;
    if (wren) begin
      cmd(sbp_pkg::CMD_WRITE_ENABLE, 26'h0, 8'h00);
      m_wel = 1;
    end
    acc = m_wel && !(m_srwd && !wp_n_in);
    cmd(sbp_pkg::CMD_WRITE_STATUS, 26'h0, d);
    if (acc) begin
      m_srwd = d[7];
      m_bp = {d[6], d[4:2]};
      m_tb = d[5];
      m_wel = 0;
    end
    wait_idle(n);
    check("busy_len", n, acc ? sbp_pkg::SRW_CYCLES_I : 0);
    check("stat", stat_out, mstat());
    rd_check();
  endtask

  // Program or erase after a write enable
  task automatic prog(sbp_pkg::sbp_cmd_code_t c, logic [25:0] a);
    bit e;
    int n;
    lag = 4'($urandom_range(0, 9));
    cmd(sbp_pkg::CMD_WRITE_ENABLE, 26'h0, 8'h00);
    e = c == sbp_pkg::CMD_WHOLE_ARRAY_ERASE ? m_bp != 0 : is_prot(a);
    cmd(c, a, 8'h00);
    check("err", prot_err_out, e);
    check("start", op_start_out, !e);
    if (!e) begin
      check("addr", op_out.addr, a);
      check("code", op_out.code, c);
    end
    // Launched work is still running when the flag read is taken
    flag_check(!e);
    m_wel = e;
    wait_idle(n);
    check("stat_op", stat_out, mstat());
  endtask

  initial begin
    int s;
    void'($urandom(32'h4e43));
    repeat (6) @(negedge mclk_in);
    rstn_in = 1'b1;
    check("rst", stat_out, 8'ha0);
    rd_check();
    wr_stat(8'h00, 0);
    cmd(sbp_pkg::CMD_PROGRAM, 26'h0, 8'h00);
    check("no_wel", op_start_out, 0);
    check("no_wel_err", prot_err_out, 0);
    for (int t = 0; t < 2; t++) begin
      for (int b = 0; b < 16; b++) begin
        wr_stat({1'b0, b[3], t[0], b[2:0], 2'($urandom)}, 1);
        s = m_tb ? nprot() - 1 : 1024 - nprot();
        prog(sbp_pkg::CMD_PROGRAM, {10'(s), 16'($urandom)});
        s = m_tb ? nprot() : 1023 - nprot();
        prog(sbp_pkg::CMD_SUBSECTOR_ERASE, {10'(s), 16'($urandom)});
        prog(sbp_pkg::CMD_SECTOR_ERASE, 26'($urandom));
        prog(sbp_pkg::CMD_WHOLE_ARRAY_ERASE, 26'h0);
      end
    end
    // Mid-run reset brings every bit back to its default
    rstn_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    rstn_in = 1'b1;
    m_srwd = 1;
    m_tb = 1;
    m_bp = 0;
    m_wel = 0;
    check("rst2", stat_out, mstat());
    rd_check();
    // Locked while the disable bit is set and the pin is low
    wr_stat(8'h80, 1);
    wp_n_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    wr_stat(8'h04, 1);
    wp_n_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    wr_stat(8'h04, 1);
    print_verdict();
  end
endmodule
